// ===== common/apdu_pkg.sv
// shared codes, limits, reset values and timing for the command handler
package apdu_pkg;
  // ==================================================
  // instruction and parameter codes
  localparam logic [7:0] INS_WR_USER = 8'hb0;
  localparam logic [7:0] INS_RD_USER = 8'hb2;
  localparam logic [7:0] INS_SYS_WR = 8'hb4;
  localparam logic [7:0] P1_CFG_WR = 8'h00;
  localparam logic [7:0] P1_FUSE = 8'h01;
  localparam logic [7:0] P1_CKSUM = 8'h02;
  localparam logic [7:0] P1_ZONE = 8'h03;
  localparam logic [7:0] P1_CFG_WR_AT = 8'h08;
  localparam logic [7:0] P1_ZONE_AT = 8'h0b;
  // ==================================================
  // status bytes; the second status byte is always zero
  localparam logic [7:0] SW_WAIT_CKS = 8'h62;
  localparam logic [7:0] SW_BAD_LEN = 8'h67;
  localparam logic [7:0] SW_UNAUTH = 8'h69;
  localparam logic [7:0] SW_BAD_ADDR = 8'h6b;
  localparam logic [7:0] SW_BAD_INS = 8'h6d;
  localparam logic [7:0] SW_OK = 8'h90;
  localparam logic [7:0] SW2_VAL = 8'h00;
  // ==================================================
  // fuse ids and bit positions in the fuse state
  localparam logic [7:0] FUSE_ID_FACTORY = 8'h06;
  localparam logic [7:0] FUSE_ID_VENDOR = 8'h04;
  localparam logic [7:0] FUSE_ID_ISSUER = 8'h00;
  localparam int FUSE_FACTORY_BIT = 0;
  localparam int FUSE_VENDOR_BIT = 1;
  localparam int FUSE_ISSUER_BIT = 2;
  localparam logic [3:0] FUSE_RST = 4'hf;
  // ==================================================
  // lengths
  localparam logic [7:0] PAGE_MAX_DEF = 8'h10;
  localparam logic [7:0] AT_MAX = 8'h08;
  localparam logic [7:0] CKS_LEN = 8'h02;
  localparam logic [8:0] LEN_ZERO_RD = 9'h100;
  localparam logic [2:0] HDR_LAST = 3'h4;
  localparam logic [15:0] ZONE_LAST_RST = 16'h00ff;
  // ==================================================
  // self-timed write cycle
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WRITE_CYCLE_US = 5000;
  // scaled in two steps so the product stays inside a 32-bit int
  localparam int WRITE_CYCLES = (WRITE_CYCLE_US * 1000) / (CLK_PERIOD_PS / 1000);
endpackage

// ===== hdl/apdu_cmd_handler.sv
// command header interpreter for user-zone and system-write commands
// ==================================================
`timescale 1ns/1ps
`default_nettype none
module apdu_cmd_handler #(
  parameter logic [7:0] PAGE_MAX = apdu_pkg::PAGE_MAX_DEF,
  parameter int WRITE_CYCLES = apdu_pkg::WRITE_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic zone_write_ok,
  input wire logic zone_read_ok,
  input wire logic [1:0] auth_write_mode,
  input wire logic [15:0] zone_last,
  input wire logic cfg_addr_ok,
  input wire logic secure_ok,
  input wire logic cks_ok,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic buf_we,
  output logic [15:0] buf_addr,
  output logic [7:0] buf_data,
  output logic commit,
  output logic commit_cfg,
  output logic commit_at,
  output logic [7:0] zone_sel,
  output logic at_zone,
  output logic [3:0] fuses,
  output logic cks_pending,
  output logic [7:0] cks_byte0,
  output logic [7:0] cks_byte1,
  output logic auth_revoke
);
  typedef enum logic [3:0] {
    S_HDR, S_DEC, S_PROC, S_DATA, S_RD, S_END, S_WAIT, S_SW1, S_SW2
  } state_t;
  typedef enum logic [1:0] {K_UWR, K_CWR, K_CKS, K_RD} kind_t;

  state_t st_r, st_nxt;
  kind_t kind_r, kind_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [7:0] ins_r, ins_nxt;
  logic [7:0] p1_r, p1_nxt;
  logic [7:0] p2_r, p2_nxt;
  logic [7:0] p3_r, p3_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [8:0] cnt_r, cnt_nxt;
  logic [7:0] sw1_r, sw1_nxt;
  logic [7:0] tx_byte_r, tx_byte_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic buf_we_r, buf_we_nxt;
  logic [15:0] buf_addr_r, buf_addr_nxt;
  logic [7:0] buf_data_r, buf_data_nxt;
  logic commit_r, commit_nxt;
  logic commit_cfg_r, commit_cfg_nxt;
  logic commit_at_r, commit_at_nxt;
  logic [7:0] zone_r, zone_nxt;
  logic at_zone_r, at_zone_nxt;
  logic [3:0] fuse_r, fuse_nxt;
  logic pend_r, pend_nxt;
  logic cfg_bad_r, cfg_bad_nxt;
  logic [7:0] cks0_r, cks0_nxt;
  logic [7:0] cks1_r, cks1_nxt;
  logic revoke_r, revoke_nxt;
  logic wr_done;
  logic [7:0] wr_max;

  // the write cycle is long, so its length is a parameter a bench can shorten
  write_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .start(commit_r),
    .done(wr_done)
  );

  // ==================================================
  // decode and sequencing
  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    idx_nxt = idx_r;
    ins_nxt = ins_r;
    p1_nxt = p1_r;
    p2_nxt = p2_r;
    p3_nxt = p3_r;
    addr_nxt = addr_r;
    cnt_nxt = cnt_r;
    sw1_nxt = sw1_r;
    tx_byte_nxt = tx_byte_r;
    tx_valid_nxt = 1'b0;
    buf_we_nxt = 1'b0;
    buf_addr_nxt = buf_addr_r;
    buf_data_nxt = buf_data_r;
    commit_nxt = 1'b0;
    commit_cfg_nxt = commit_cfg_r;
    commit_at_nxt = commit_at_r;
    zone_nxt = zone_r;
    at_zone_nxt = at_zone_r;
    fuse_nxt = fuse_r;
    pend_nxt = pend_r;
    cfg_bad_nxt = cfg_bad_r;
    cks0_nxt = cks0_r;
    cks1_nxt = cks1_r;
    revoke_nxt = 1'b0;
    wr_max = PAGE_MAX;
    case (st_r)
      S_HDR: begin
        if (rx_valid) begin
          // the class byte is taken and dropped
          case (idx_r)
            3'h1: ins_nxt = rx_byte;
            3'h2: begin
              p1_nxt = rx_byte;
              addr_nxt[15:8] = rx_byte;
            end
            3'h3: begin
              p2_nxt = rx_byte;
              addr_nxt[7:0] = rx_byte;
            end
            3'h4: p3_nxt = rx_byte;
            default: ;
          endcase
          if (idx_r == apdu_pkg::HDR_LAST) begin
            idx_nxt = 3'h0;
            st_nxt = S_DEC;
          end else begin
            idx_nxt = idx_r + 3'h1;
          end
        end
      end
      S_DEC: begin
        st_nxt = S_SW1;
        case (ins_r)
          apdu_pkg::INS_WR_USER: begin
            wr_max = at_zone_r ? apdu_pkg::AT_MAX : PAGE_MAX;
            if (!zone_write_ok) begin
              sw1_nxt = apdu_pkg::SW_UNAUTH;
            end else if (p3_r > wr_max || p3_r == 8'h0) begin
              sw1_nxt = apdu_pkg::SW_BAD_LEN;
            end else begin
              kind_nxt = K_UWR;
              cnt_nxt = {1'b0, p3_r};
              st_nxt = S_PROC;
            end
          end
          apdu_pkg::INS_RD_USER: begin
            if (!zone_read_ok) begin
              sw1_nxt = apdu_pkg::SW_UNAUTH;
            end else begin
              kind_nxt = K_RD;
              cnt_nxt = (p3_r == 8'h0) ? apdu_pkg::LEN_ZERO_RD : {1'b0, p3_r};
              st_nxt = S_PROC;
            end
          end
          apdu_pkg::INS_SYS_WR: begin
            case (p1_r)
              apdu_pkg::P1_CFG_WR, apdu_pkg::P1_CFG_WR_AT: begin
                // only P2 addresses the configuration memory
                addr_nxt = {8'h0, p2_r};
                wr_max = (p1_r == apdu_pkg::P1_CFG_WR_AT) ? apdu_pkg::AT_MAX : PAGE_MAX;
                if (!cfg_addr_ok) begin
                  sw1_nxt = apdu_pkg::SW_UNAUTH;
                end else if (p3_r > wr_max || p3_r == 8'h0) begin
                  sw1_nxt = apdu_pkg::SW_BAD_LEN;
                end else begin
                  kind_nxt = K_CWR;
                  cnt_nxt = {1'b0, p3_r};
                  cfg_bad_nxt = 1'b0;
                  st_nxt = S_PROC;
                end
              end
              apdu_pkg::P1_FUSE: begin
                sw1_nxt = apdu_pkg::SW_OK;
                if (p3_r != 8'h0) begin
                  sw1_nxt = apdu_pkg::SW_BAD_LEN;
                end else if (!secure_ok) begin
                  sw1_nxt = apdu_pkg::SW_UNAUTH;
                end else if (p2_r == apdu_pkg::FUSE_ID_FACTORY) begin
                  fuse_nxt[apdu_pkg::FUSE_FACTORY_BIT] = 1'b0;
                end else if (p2_r == apdu_pkg::FUSE_ID_VENDOR) begin
                  if (fuse_r[apdu_pkg::FUSE_FACTORY_BIT]) begin
                    sw1_nxt = apdu_pkg::SW_UNAUTH;
                  end else begin
                    fuse_nxt[apdu_pkg::FUSE_VENDOR_BIT] = 1'b0;
                  end
                end else if (p2_r == apdu_pkg::FUSE_ID_ISSUER) begin
                  if (fuse_r[apdu_pkg::FUSE_VENDOR_BIT]) begin
                    sw1_nxt = apdu_pkg::SW_UNAUTH;
                  end else begin
                    fuse_nxt[apdu_pkg::FUSE_ISSUER_BIT] = 1'b0;
                  end
                end else begin
                  sw1_nxt = apdu_pkg::SW_BAD_ADDR;
                end
              end
              apdu_pkg::P1_CKSUM: begin
                if (p3_r != apdu_pkg::CKS_LEN) begin
                  sw1_nxt = apdu_pkg::SW_BAD_LEN;
                end else begin
                  kind_nxt = K_CKS;
                  cnt_nxt = {1'b0, apdu_pkg::CKS_LEN};
                  st_nxt = S_PROC;
                end
              end
              apdu_pkg::P1_ZONE, apdu_pkg::P1_ZONE_AT: begin
                if (p3_r != 8'h0) begin
                  sw1_nxt = apdu_pkg::SW_BAD_LEN;
                end else begin
                  zone_nxt = p2_r;
                  at_zone_nxt = (p1_r == apdu_pkg::P1_ZONE_AT);
                  sw1_nxt = apdu_pkg::SW_OK;
                end
              end
              default: sw1_nxt = apdu_pkg::SW_BAD_ADDR;
            endcase
          end
          default: sw1_nxt = apdu_pkg::SW_BAD_INS;
        endcase
      end
      S_PROC: begin
        if (tx_ready) begin
          tx_byte_nxt = ins_r;
          tx_valid_nxt = 1'b1;
          st_nxt = (kind_r == K_RD) ? S_RD : S_DATA;
        end
      end
      S_RD: begin
        // mem_rdata follows mem_addr within the cycle
        if (tx_ready) begin
          tx_byte_nxt = mem_rdata;
          tx_valid_nxt = 1'b1;
          addr_nxt = (addr_r == zone_last) ? 16'h0 : addr_r + 16'h1;
          cnt_nxt = cnt_r - 9'h1;
          if (cnt_r == 9'h1) begin
            sw1_nxt = apdu_pkg::SW_OK;
            st_nxt = S_SW1;
          end
        end
      end
      S_DATA: begin
        if (rx_valid) begin
          if (kind_r == K_CKS) begin
            if (cnt_r == 9'h2) begin
              cks0_nxt = rx_byte;
            end else begin
              cks1_nxt = rx_byte;
            end
          end else begin
            // every byte goes to the page buffer; the host loads each once
            buf_we_nxt = 1'b1;
            buf_addr_nxt = addr_r;
            buf_data_nxt = rx_byte;
            addr_nxt = addr_r + 16'h1;
            if (kind_r == K_CWR && !cfg_addr_ok) begin
              cfg_bad_nxt = 1'b1;
            end
          end
          cnt_nxt = cnt_r - 9'h1;
          if (cnt_r == 9'h1) begin
            st_nxt = S_END;
          end
        end
      end
      S_END: begin
        st_nxt = S_SW1;
        case (kind_r)
          K_UWR: begin
            commit_cfg_nxt = 1'b0;
            commit_at_nxt = at_zone_r;
            if (!auth_write_mode[1]) begin
              pend_nxt = 1'b1;
              sw1_nxt = apdu_pkg::SW_WAIT_CKS;
            end else begin
              commit_nxt = 1'b1;
              st_nxt = S_WAIT;
            end
          end
          K_CWR: begin
            commit_cfg_nxt = 1'b1;
            commit_at_nxt = (p1_r == apdu_pkg::P1_CFG_WR_AT);
            if (cfg_bad_r) begin
              sw1_nxt = apdu_pkg::SW_UNAUTH;
            end else begin
              commit_nxt = 1'b1;
              st_nxt = S_WAIT;
            end
          end
          default: begin
            pend_nxt = 1'b0;
            if (cks_ok && pend_r) begin
              commit_nxt = 1'b1;
              st_nxt = S_WAIT;
            end else if (cks_ok) begin
              sw1_nxt = apdu_pkg::SW_OK;
            end else begin
              revoke_nxt = 1'b1;
              sw1_nxt = apdu_pkg::SW_UNAUTH;
            end
          end
        endcase
      end
      S_WAIT: begin
        if (wr_done) begin
          sw1_nxt = apdu_pkg::SW_OK;
          st_nxt = S_SW1;
        end
      end
      S_SW1: begin
        if (tx_ready) begin
          tx_byte_nxt = sw1_r;
          tx_valid_nxt = 1'b1;
          st_nxt = S_SW2;
        end
      end
      S_SW2: begin
        if (tx_ready) begin
          tx_byte_nxt = apdu_pkg::SW2_VAL;
          tx_valid_nxt = 1'b1;
          st_nxt = S_HDR;
        end
      end
      default: st_nxt = S_HDR;
    endcase
  end

  // ==================================================
  // state registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= S_HDR;
      kind_r <= K_UWR;
      idx_r <= 3'h0;
      ins_r <= 8'h0;
      p1_r <= 8'h0;
      p2_r <= 8'h0;
      p3_r <= 8'h0;
      addr_r <= 16'h0;
      cnt_r <= 9'h0;
      sw1_r <= 8'h0;
      tx_byte_r <= 8'h0;
      tx_valid_r <= 1'b0;
      buf_we_r <= 1'b0;
      buf_addr_r <= 16'h0;
      buf_data_r <= 8'h0;
      commit_r <= 1'b0;
      commit_cfg_r <= 1'b0;
      commit_at_r <= 1'b0;
      zone_r <= 8'h0;
      at_zone_r <= 1'b0;
      fuse_r <= apdu_pkg::FUSE_RST;
      pend_r <= 1'b0;
      cfg_bad_r <= 1'b0;
      cks0_r <= 8'h0;
      cks1_r <= 8'h0;
      revoke_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      idx_r <= idx_nxt;
      ins_r <= ins_nxt;
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      p3_r <= p3_nxt;
      addr_r <= addr_nxt;
      cnt_r <= cnt_nxt;
      sw1_r <= sw1_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_valid_r <= tx_valid_nxt;
      buf_we_r <= buf_we_nxt;
      buf_addr_r <= buf_addr_nxt;
      buf_data_r <= buf_data_nxt;
      commit_r <= commit_nxt;
      commit_cfg_r <= commit_cfg_nxt;
      commit_at_r <= commit_at_nxt;
      zone_r <= zone_nxt;
      at_zone_r <= at_zone_nxt;
      fuse_r <= fuse_nxt;
      pend_r <= pend_nxt;
      cfg_bad_r <= cfg_bad_nxt;
      cks0_r <= cks0_nxt;
      cks1_r <= cks1_nxt;
      revoke_r <= revoke_nxt;
    end
  end

  assign tx_byte = tx_byte_r;
  assign tx_valid = tx_valid_r;
  assign mem_addr = addr_r;
  assign buf_we = buf_we_r;
  assign buf_addr = buf_addr_r;
  assign buf_data = buf_data_r;
  assign commit = commit_r;
  assign commit_cfg = commit_cfg_r;
  assign commit_at = commit_at_r;
  assign zone_sel = zone_r;
  assign at_zone = at_zone_r;
  assign fuses = fuse_r;
  assign cks_pending = pend_r;
  assign cks_byte0 = cks0_r;
  assign cks_byte1 = cks1_r;
  assign auth_revoke = revoke_r;

  // ==================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_proc_echo: assert property ((st_r == S_PROC && tx_ready) |=>
    (tx_valid && tx_byte == ins_r)) else $error("procedure byte is not INS");
  a_rd_wrap: assert property ((st_r == S_RD && tx_ready && addr_r == zone_last) |=>
    (addr_r == 16'h0)) else $error("read address did not wrap");
  a_fuse_one_way: assert property (1'b1 |=> ((fuse_r & ~$past(fuse_r)) == 4'h0))
    else $error("fuse went back to one");
  a_fuse_secure: assert property ((fuse_r != $past(fuse_r)) |-> $past(secure_ok))
    else $error("fuse blown without secure code");
  a_fuse_order: assert property ((!fuse_r[2] |-> !fuse_r[1]) and (!fuse_r[1] |-> !fuse_r[0]))
    else $error("fuse blown out of order");
  a_unauth_write: assert property ((st_r == S_DEC && ins_r == apdu_pkg::INS_WR_USER &&
    !zone_write_ok) |=> (st_r == S_SW1 && sw1_r == apdu_pkg::SW_UNAUTH)[*1] ##1 (!buf_we)[*2])
    else $error("unauthorized write not refused");
  a_len_refuse: assert property ((st_r == S_DEC && ins_r == apdu_pkg::INS_WR_USER &&
    zone_write_ok && at_zone_r && p3_r > apdu_pkg::AT_MAX) |=> sw1_r == apdu_pkg::SW_BAD_LEN)
    else $error("overlong anti-tearing write accepted");
  a_bad_cks: assert property ((st_r == S_END && kind_r == K_CKS && !cks_ok) |=>
    (auth_revoke && !commit && sw1_r == apdu_pkg::SW_UNAUTH)) else $error("bad checksum kept");
  a_cfg_block: assert property ((st_r == S_END && kind_r == K_CWR && cfg_bad_r) |=>
    (!commit ##1 !commit)) else $error("config write ran into bad address");
  a_bad_ins: assert property ((st_r == S_DEC && ins_r != apdu_pkg::INS_WR_USER &&
    ins_r != apdu_pkg::INS_RD_USER && ins_r != apdu_pkg::INS_SYS_WR) |=>
    sw1_r == apdu_pkg::SW_BAD_INS) else $error("unknown instruction accepted");

  c_read: cover property (st_r == S_RD && tx_ready && cnt_r == 9'h1);
  c_write: cover property (commit && !commit_cfg);
  c_wait_cks: cover property (st_r == S_END && kind_r == K_UWR && !auth_write_mode[1]);
  c_fuse: cover property (fuse_r != $past(fuse_r));
endmodule
`default_nettype wire

// ===== hdl/write_timer.sv
// self-timed nonvolatile write cycle counter
`timescale 1ns/1ps
`default_nettype none
module write_timer #(
  parameter int CYCLES = 1000000
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic start,
  output logic done
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic run_r;
  logic run_nxt;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt = 32'(CYCLES - 1);
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r == 32'h0) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 32'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 32'h0;
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done <= done_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== verification/reader_model.sv
// reader-side model: takes card bytes, stalls on request, serves memory data
`timescale 1ns/1ps
`default_nettype none
module reader_model #(
  parameter logic [7:0] CFG_LIM = 8'h40
) (
  input wire logic mclk,
  input wire logic hold,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata,
  output logic cfg_addr_ok
);
  logic [7:0] got [$];
  // ==================================================
  // link side
  assign tx_ready = !hold;
  // sampled mid-cycle so the bench never races the card's register update
  always @(negedge mclk) begin
    if (tx_valid === 1'b1) begin
      got.push_back(tx_byte);
    end
  end
  // ==================================================
  // storage side; data is an address scramble so every byte is predictable
  assign mem_rdata = mem_addr[7:0] ^ 8'h5a;
  assign cfg_addr_ok = mem_addr[7:0] < CFG_LIM;
endmodule
`default_nettype wire

// ===== verification/test_apdu_cmd_handler.sv
// randomised command-level bench for the command handler
`timescale 1ns/1ps
`default_nettype none
module test_apdu_cmd_handler;
  logic mclk, rstn, rx_valid, tx_ready, tx_valid, zone_write_ok, zone_read_ok, cfg_addr_ok;
  logic secure_ok, cks_ok, buf_we, commit, commit_cfg, commit_at, at_zone, cks_pending;
  logic auth_revoke, hold, bon;
  logic [7:0] rx_byte, tx_byte, mem_rdata, buf_data, zone_sel, cks_byte0, cks_byte1, a;
  logic [1:0] auth_write_mode;
  logic [15:0] zone_last, mem_addr, buf_addr, bstart;
  logic [3:0] fuses;
  logic [7:0] lfsr = 8'h5c;
  logic [7:0] dat [0:15];
  logic [39:0] tbl [0:7];
  logic [19:0] fz [0:3];
  int failures, n_tests, ncommit, nrev, bk, i, k, c0;

  apdu_cmd_handler #(.WRITE_CYCLES(20)) apdu_cmd_handler_i (
    .mclk(mclk), .rstn(rstn), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .zone_write_ok(zone_write_ok),
    .zone_read_ok(zone_read_ok), .auth_write_mode(auth_write_mode), .zone_last(zone_last),
    .cfg_addr_ok(cfg_addr_ok), .secure_ok(secure_ok), .cks_ok(cks_ok), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .buf_we(buf_we), .buf_addr(buf_addr), .buf_data(buf_data),
    .commit(commit), .commit_cfg(commit_cfg), .commit_at(commit_at), .zone_sel(zone_sel),
    .at_zone(at_zone), .fuses(fuses), .cks_pending(cks_pending), .cks_byte0(cks_byte0),
    .cks_byte1(cks_byte1), .auth_revoke(auth_revoke));
  reader_model reader_model_i (.mclk(mclk), .hold(hold), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .cfg_addr_ok(cfg_addr_ok));

  // ==================================================
  // helpers
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [15:0] g(input int n);
    return {8'h00, reader_model_i.got[n]};
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task tail(input logic [7:0] s);
    k = reader_model_i.got.size();
    chk(g(k - 2), {8'h00, s});
    chk(g(k - 1), 16'h0000);
  endtask
  // each data byte goes out once per command; no page position is loaded twice
  task xfer(input logic [7:0] ins, p1, p2, p3, input int nd, input int nrx);
    logic [7:0] h [0:4];
    h = '{8'h00, ins, p1, p2, p3};
    for (i = 0; i < 16; i++) dat[i] = lfsr ^ 8'(i * 37);
    bstart = (ins == apdu_pkg::INS_SYS_WR) ? {8'h00, p2} : {p1, p2};
    bon = !(ins == apdu_pkg::INS_SYS_WR && p1 == apdu_pkg::P1_CKSUM);
    bk = 0;
    reader_model_i.got.delete();
    for (i = 0; i < 5; i++) begin
      rx_byte <= h[i];
      rx_valid <= 1'b1;
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
    for (i = 0; i < 1000 && reader_model_i.got.size() == 0; i++) @(posedge mclk);
    if (nd > 0 && reader_model_i.got.size() > 0 && reader_model_i.got[0] === ins) begin
      for (i = 0; i < nd; i++) begin
        rx_byte <= dat[i];
        rx_valid <= 1'b1;
        @(posedge mclk);
      end
      rx_valid <= 1'b0;
    end
    for (i = 0; i < 1000 && reader_model_i.got.size() < nrx; i++) @(posedge mclk);
    chk(16'(reader_model_i.got.size()), 16'(nrx));
    if (reader_model_i.got.size() != nrx) begin
      close_out();
    end
  endtask

  // ==================================================
  // clock, random stalls, side-effect watchers
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    lfsr <= nx(lfsr);
    hold <= lfsr[0] & lfsr[1];
    if (commit === 1'b1) ncommit++;
    if (auth_revoke === 1'b1) nrev++;
    if (buf_we === 1'b1 && bon) begin
      chk(buf_addr, bstart + 16'(bk));
      chk({8'h00, buf_data}, {8'h00, dat[bk]});
      bk++;
    end
  end

  // ==================================================
  // main sequence
  initial begin
    {rstn, rx_valid, rx_byte, secure_ok, cks_ok, bon} = '0;
    {zone_write_ok, zone_read_ok, auth_write_mode, zone_last} = {4'hf, 16'h0007};
    tbl = '{40'hc0000000_6d, 40'hb0000000_67, 40'hb0000011_67, 40'hb4005001_69,
      40'hb4080009_67, 40'hb4010600_69, 40'hb4050000_6b, 40'hb4020001_67};
    fz = '{20'h04_69_f, 20'h06_90_e, 20'h04_90_c, 20'h00_90_8};
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    c0 = ncommit;
    for (int e = 0; e < 8; e++) begin
      xfer(tbl[e][39:32], tbl[e][31:24], tbl[e][23:16], tbl[e][15:8], 0, 2);
      chk(g(0), {8'h00, tbl[e][7:0]});
    end
    // secure code present from here, so the first refusal is down to fuse order
    secure_ok <= 1'b1;
    foreach (fz[e]) begin
      xfer(8'hb4, 8'h01, fz[e][19:12], 8'h00, 0, 2);
      chk(g(0), {8'h00, fz[e][11:4]});
      chk({12'h000, fuses}, {12'h000, fz[e][3:0]});
    end
    foreach (tbl[e]) if (e < 2) begin
      xfer(8'hb0, 8'h00, 8'h02, e ? 8'h10 : 8'h04, e ? 16 : 4, 3);
      chk(g(0), 16'h00b0);
      tail(8'h90);
      chk(16'(ncommit), 16'(c0 + e + 1));
    end
    zone_write_ok <= 1'b0;
    xfer(8'hb0, 8'h00, 8'h02, 8'h04, 4, 2);
    chk(g(0), 16'h0069);
    chk(16'(bk), 16'h0000);
    zone_write_ok <= 1'b1;
    xfer(8'hb4, 8'h0b, 8'h05, 8'h00, 0, 2);
    chk({8'h00, zone_sel}, 16'h0005);
    chk({15'h0, at_zone}, 16'h0001);
    xfer(8'hb0, 8'h00, 8'h00, 8'h09, 0, 2);
    chk(g(0), 16'h0067);
    xfer(8'hb0, 8'h00, 8'h00, 8'h08, 8, 3);
    chk({15'h0, commit_at}, 16'h0001);
    xfer(8'hb4, 8'h03, 8'h06, 8'h00, 0, 2);
    chk({15'h0, at_zone}, 16'h0000);
    xfer(8'hb4, 8'h08, 8'h10, 8'h08, 8, 3);
    chk({14'h0, commit_at, commit_cfg}, 16'h0003);
    c0 = ncommit;
    xfer(8'hb4, 8'h00, 8'h3f, 8'h02, 2, 3);
    tail(8'h69);
    chk(16'(ncommit), 16'(c0));
    xfer(8'hb2, 8'h00, 8'h06, 8'h00, 0, 259);
    a = 8'h06;
    for (int n = 1; n <= 256; n++) begin
      chk(g(n), {8'h00, a ^ 8'h5a});
      a = (a == 8'h07) ? 8'h00 : a + 8'h01;
    end
    tail(8'h90);
    zone_read_ok <= 1'b0;
    xfer(8'hb2, 8'h00, 8'h00, 8'h04, 0, 2);
    chk(g(0), 16'h0069);
    auth_write_mode <= 2'b01;
    for (int p = 0; p < 2; p++) begin
      c0 = ncommit;
      xfer(8'hb0, 8'h00, 8'h01, 8'h02, 2, 3);
      tail(8'h62);
      chk({15'h0, cks_pending}, 16'h0001);
      cks_ok <= p[0];
      k = nrev;
      xfer(8'hb4, 8'h02, 8'h00, 8'h02, 2, 3);
      chk({cks_byte0, cks_byte1}, {dat[0], dat[1]});
      // count before tail, which reuses k
      chk(16'(nrev - k + ncommit - c0), 16'h0001);
      tail(p ? 8'h90 : 8'h69);
      chk({15'h0, cks_pending}, 16'h0000);
    end
    close_out();
  end
endmodule
`default_nettype wire
